/* qec_counter.sv */
`timescale 1ns/1ps
`include "qec_regs.svh"
module qec_counter (
    // Clock, reset and clock enable.
    input  wire logic                MCLK,
    input  wire logic                RESET,
    input  wire logic                CLOCK_ENABLE,
    // Encoder track pins.
    input  wire logic                TRACK_A_POS_IN,
    input  wire logic                TRACK_A_NEG_IN,
    input  wire logic                TRACK_B_POS_IN,
    input  wire logic                TRACK_B_NEG_IN,
    input  wire logic                TRACK_C_POS_IN,
    input  wire logic                TRACK_C_NEG_IN,
    // Probe pin and software capture.
    input  wire logic                PROBE_TRIGGER_IN,
    input  wire logic                PROBE_CAPTURE_COMMAND,
    // Configuration write from either host port.
    input  wire qec_pkg::qec_cfg_t   CONFIG_DATA,
    input  wire logic                CONFIG_WRITE,
    input  wire logic                STATUS_CLEAR,
    // Error and warning lines.
    input  wire logic                ERROR_LINE_LOW_IN,
    output logic                     ERROR_LINE_LOW_OUT,
    output logic                     ERROR_LINE_LOW_OE,
    input  wire logic                WARNING_LINE_LOW_IN,
    output logic                     WARNING_LINE_LOW_OUT,
    output logic                     WARNING_LINE_LOW_OE,
    // Serial return pin and its open-level detector.
    input  wire logic                SERIAL_RETURN_OPEN_IN,
    output logic                     SYNC_SERIAL_SELECT,
    // Readout.
    output logic [47:0]              COUNTER_FIRST,
    output logic [47:0]              COUNTER_SECOND,
    output logic [47:0]              COUNTER_THIRD,
    output logic [23:0]              PROBE_CAPTURE_LATEST,
    output logic [23:0]              PROBE_CAPTURE_PREVIOUS,
    output logic [23:0]              INDEX_DISTANCE_LATCH,
    output logic [23:0]              INDEX_DISTANCE_COUNT,
    output qec_pkg::qec_status_t     STATUS,
    // Sensor serial link.
    input  wire logic                LINK_CLK,
    input  wire logic                LINK_FRAME_IN,
    output logic                     LINK_DATA_OUT
);
    import qec_pkg::*;

    localparam int CW = `QEC_CNT_W;
    localparam int IW = `QEC_IDX_W;
    localparam int FW = `QEC_FRAME_W;

    qec_cfg_t          cfg_ff;
    logic [9:0]        pin_s1_ff;
    logic [9:0]        pin_s2_ff;
    logic [9:0]        pins;
    logic              multi;
    logic [2:0]        ta;
    logic [2:0]        tb;
    logic              idx_trk;
    logic [2:0]        step;
    logic [2:0]        up;
    logic [2:0]        both;
    logic [CW-1:0]     cnt_ff [3];
    logic [CW-1:0]     mask [3];
    logic [1:0]        ab_prev_ff [3];
    logic [2:0]        abz_err_ff;
    logic [2:0]        ovf_ff;
    logic              idx_prev_ff;
    logic              idx_rise;
    logic              idx_seen_ff;
    logic [IW-1:0]     idx_cnt_ff;
    logic [IW-1:0]     idx_latch_ff;
    logic              idx_lval_ff;
    logic              idx_ovf_ff;
    logic              prb_prev_ff;
    logic              prb_hit;
    logic              prb_trig;
    logic [23:0]       tp1_ff;
    logic [23:0]       tp2_ff;
    logic              prb_val_ff;
    logic              pwr_ff;
    logic              ext_err_ff;
    logic              ext_warn_ff;
    logic              err_drv_ff;
    logic              warn_drv_ff;
    logic [2:0]        err_hist_ff;
    logic [2:0]        warn_hist_ff;
    logic [`QEC_FILT_W-1:0] filt_ff;
    logic              ssel_ff;
    logic [FW-1:0]     snap_ff;
    logic              req_ff;
    logic              ack_s1_ff;
    logic              ack_s2_ff;
    qec_lnk_t              lnk_st_ff;
    logic                  lnk_rst_s1_ff;
    logic                  lnk_rst_ff;
    logic                  lnk_req_s1_ff;
    logic                  lnk_req_s2_ff;
    logic                  lnk_ack_ff;
    logic [FW-1:0]         lnk_hold_ff;
    logic [FW-1:0]         lnk_sh_ff;
    logic [`QEC_FRAME_CW-1:0] lnk_bit_ff;
    logic                  lnk_do_ff;

    function automatic logic [5:0] chan_w(input logic [2:0] lay, input int k);
        logic [5:0] w;
        w = `QEC_W0;
        case (lay)
            `QEC_LAY_1X24:  w = (k == 0) ? `QEC_W24 : `QEC_W0;
            `QEC_LAY_1X16:  w = (k == 0) ? `QEC_W16 : `QEC_W0;
            `QEC_LAY_1X32:  w = (k == 0) ? `QEC_W32 : `QEC_W0;
            `QEC_LAY_1X48:  w = (k == 0) ? `QEC_W48 : `QEC_W0;
            `QEC_LAY_2X24:  w = (k == 2) ? `QEC_W0 : `QEC_W24;
            `QEC_LAY_2X16:  w = (k == 2) ? `QEC_W0 : `QEC_W16;
            `QEC_LAY_32_16: w = (k == 0) ? `QEC_W32 : ((k == 1) ? `QEC_W16 : `QEC_W0);
            `QEC_LAY_3X16:  w = `QEC_W16;
            default:        w = `QEC_W0;
        endcase
        return w;
    endfunction

    always_ff @(posedge MCLK) begin
        if (RESET) begin
            cfg_ff <= `QEC_CFG_RST;
        end else if (CLOCK_ENABLE && CONFIG_WRITE) begin
            cfg_ff <= CONFIG_DATA;
        end
    end

    // Every track, probe, line and return pin passes two flip-flops before any logic reads it.
    // The error and warning lines reset to their released high level, so no false external flag.
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            pin_s1_ff <= `QEC_PIN_RST;
            pin_s2_ff <= `QEC_PIN_RST;
        end else if (CLOCK_ENABLE) begin
            pin_s1_ff <= {SERIAL_RETURN_OPEN_IN, WARNING_LINE_LOW_IN, ERROR_LINE_LOW_IN,
                          PROBE_TRIGGER_IN, TRACK_C_NEG_IN, TRACK_C_POS_IN, TRACK_B_NEG_IN,
                          TRACK_B_POS_IN, TRACK_A_NEG_IN, TRACK_A_POS_IN};
            pin_s2_ff <= pin_s1_ff;
        end
    end
    assign pins = pin_s2_ff;

    // Single-ended or split layouts use each pin pair as one channel.
    always_comb begin
        multi   = (cfg_ff.layout >= `QEC_LAY_2X24);
        ta      = {pins[4], pins[2], pins[0]};
        tb      = {pins[5], pins[3], (multi || cfg_ff.ttl_mode) ? pins[1] : pins[2]};
        idx_trk = (cfg_ff.ttl_mode && !multi) ? pins[2] : pins[4];
    end

    genvar k;
    generate
        for (k = 0; k < 3; k++) begin : g_ch
            logic [CW-1:0] nxt_cnt;
            assign mask[k] = CW'((49'h1 << chan_w(cfg_ff.layout, k)) - 49'h1);
            assign both[k] = (ab_prev_ff[k][1] != ta[k]) && (ab_prev_ff[k][0] != tb[k]);
            assign step[k] = ((ab_prev_ff[k][1] != ta[k]) ^ (ab_prev_ff[k][0] != tb[k]))
                             && (mask[k] != '0);
            assign up[k]   = ta[k] ^ ab_prev_ff[k][0];
            assign nxt_cnt = (up[k] ? cnt_ff[k] + 48'h1 : cnt_ff[k] - 48'h1) & mask[k];

            always_ff @(posedge MCLK) begin
                if (RESET) begin
                    ab_prev_ff[k] <= 2'h0;
                    cnt_ff[k]     <= 48'h0;
                end else if (CLOCK_ENABLE) begin
                    ab_prev_ff[k] <= {ta[k], tb[k]};
                    if (step[k]) begin
                        cnt_ff[k] <= nxt_cnt;
                    end
                end
            end

            always_ff @(posedge MCLK) begin
                if (RESET) begin
                    abz_err_ff[k] <= 1'b0;
                    ovf_ff[k]     <= 1'b0;
                end else if (CLOCK_ENABLE) begin
                    if (both[k] && mask[k] != '0) begin
                        abz_err_ff[k] <= 1'b1;
                    end else if (STATUS_CLEAR) begin
                        abz_err_ff[k] <= 1'b0;
                    end
                    if (step[k] && (up[k] ? cnt_ff[k] == mask[k] : cnt_ff[k] == '0)) begin
                        ovf_ff[k] <= 1'b1;
                    end else if (STATUS_CLEAR) begin
                        ovf_ff[k] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    assign idx_rise = idx_trk && !idx_prev_ff;

    always_ff @(posedge MCLK) begin
        if (RESET) begin
            idx_prev_ff  <= 1'b0;
            idx_seen_ff  <= 1'b0;
            idx_cnt_ff   <= 24'h0;
            idx_latch_ff <= 24'h0;
            idx_lval_ff  <= 1'b0;
        end else if (CLOCK_ENABLE) begin
            idx_prev_ff <= idx_trk;
            if (idx_rise) begin
                idx_seen_ff <= 1'b1;
                idx_cnt_ff  <= 24'h0;
                if (idx_seen_ff) begin
                    idx_latch_ff <= idx_cnt_ff;
                    idx_lval_ff  <= 1'b1;
                end
            end else if (idx_seen_ff && step[0]) begin
                idx_cnt_ff <= up[0] ? idx_cnt_ff + 24'h1 : idx_cnt_ff - 24'h1;
            end
        end
    end

    always_ff @(posedge MCLK) begin
        if (RESET) begin
            idx_ovf_ff <= 1'b0;
        end else if (CLOCK_ENABLE) begin
            if (!idx_rise && idx_seen_ff && step[0] && up[0] && (&idx_cnt_ff)) begin
                idx_ovf_ff <= 1'b1;
            end else if (STATUS_CLEAR) begin
                idx_ovf_ff <= 1'b0;
            end
        end
    end

    always_comb begin
        case (cfg_ff.probe_edge)
            `QEC_EDGE_RISE: prb_hit = pins[6] && !prb_prev_ff;
            `QEC_EDGE_FALL: prb_hit = !pins[6] && prb_prev_ff;
            default:        prb_hit = pins[6] != prb_prev_ff;
        endcase
        prb_trig = prb_hit || PROBE_CAPTURE_COMMAND;
    end

    always_ff @(posedge MCLK) begin
        if (RESET) begin
            prb_prev_ff <= 1'b0;
            tp1_ff      <= 24'h0;
            tp2_ff      <= 24'h0;
            prb_val_ff  <= 1'b0;
        end else if (CLOCK_ENABLE) begin
            prb_prev_ff <= pins[6];
            if (prb_trig) begin
                tp1_ff     <= cnt_ff[0][23:0];
                tp2_ff     <= tp1_ff;
                prb_val_ff <= 1'b1;
            end else if (STATUS_CLEAR) begin
                prb_val_ff <= 1'b0;
            end
        end
    end

    // Own drive is masked for three cycles so the line's release is not seen as external.
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            err_drv_ff   <= 1'b0;
            warn_drv_ff  <= 1'b0;
            err_hist_ff  <= 3'h0;
            warn_hist_ff <= 3'h0;
            ext_err_ff   <= 1'b0;
            ext_warn_ff  <= 1'b0;
            pwr_ff       <= 1'b1;
        end else if (CLOCK_ENABLE) begin
            err_drv_ff   <= |abz_err_ff;
            warn_drv_ff  <= (|ovf_ff) || idx_ovf_ff;
            err_hist_ff  <= {err_hist_ff[1:0], err_drv_ff};
            warn_hist_ff <= {warn_hist_ff[1:0], warn_drv_ff};
            if (!pins[7] && !err_drv_ff && err_hist_ff == 3'h0) begin
                ext_err_ff <= 1'b1;
            end else if (STATUS_CLEAR) begin
                ext_err_ff <= 1'b0;
            end
            if (!pins[8] && !warn_drv_ff && warn_hist_ff == 3'h0) begin
                ext_warn_ff <= 1'b1;
            end else if (STATUS_CLEAR) begin
                ext_warn_ff <= 1'b0;
            end
            if (STATUS_CLEAR) begin
                pwr_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge MCLK) begin
        if (RESET) begin
            filt_ff <= '0;
            ssel_ff <= 1'b0;
        end else if (CLOCK_ENABLE) begin
            if (!pins[9]) begin
                filt_ff <= '0;
                ssel_ff <= 1'b0;
            end else if (filt_ff == `QEC_FILT_W'(`QEC_FILT_CYC)) begin
                ssel_ff <= 1'b1;
            end else begin
                filt_ff <= filt_ff + `QEC_FILT_W'(1);
            end
        end
    end

    // Frame snapshot handed to the link by a toggle request and acknowledge.
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            snap_ff   <= '0;
            req_ff    <= 1'b0;
            ack_s1_ff <= 1'b0;
            ack_s2_ff <= 1'b0;
        end else if (CLOCK_ENABLE) begin
            ack_s1_ff <= lnk_ack_ff;
            ack_s2_ff <= ack_s1_ff;
            if (ack_s2_ff == req_ff) begin
                snap_ff <= {cnt_ff[0], tp1_ff, tp2_ff, idx_latch_ff};
                req_ff  <= !req_ff;
            end
        end
    end

    assign ERROR_LINE_LOW_OUT     = 1'b0;
    assign ERROR_LINE_LOW_OE      = err_drv_ff;
    assign WARNING_LINE_LOW_OUT   = 1'b0;
    assign WARNING_LINE_LOW_OE    = warn_drv_ff;
    assign SYNC_SERIAL_SELECT     = ssel_ff;
    assign COUNTER_FIRST          = cnt_ff[0];
    assign COUNTER_SECOND         = cnt_ff[1];
    assign COUNTER_THIRD          = cnt_ff[2];
    assign PROBE_CAPTURE_LATEST   = tp1_ff;
    assign PROBE_CAPTURE_PREVIOUS = tp2_ff;
    assign INDEX_DISTANCE_LATCH   = idx_latch_ff;
    assign INDEX_DISTANCE_COUNT   = idx_cnt_ff;
    assign STATUS = '{abz_error: abz_err_ff, overflow: ovf_ff, probe_valid: prb_val_ff,
                      idx_valid: idx_seen_ff, idx_latch_valid: idx_lval_ff,
                      idx_overflow: idx_ovf_ff, power_on: pwr_ff, ext_error: ext_err_ff,
                      ext_warning: ext_warn_ff, sync_serial: ssel_ff};

    // Link domain; its clock may stand still between frames.
    always_ff @(posedge LINK_CLK) begin
        lnk_rst_s1_ff <= RESET;
        lnk_rst_ff    <= lnk_rst_s1_ff;
        if (lnk_rst_ff) begin
            lnk_req_s1_ff <= 1'b0;
            lnk_req_s2_ff <= 1'b0;
            lnk_ack_ff    <= 1'b0;
            lnk_hold_ff   <= '0;
        end else begin
            lnk_req_s1_ff <= req_ff;
            lnk_req_s2_ff <= lnk_req_s1_ff;
            if (lnk_req_s2_ff != lnk_ack_ff) begin
                lnk_hold_ff <= snap_ff;
                lnk_ack_ff  <= lnk_req_s2_ff;
            end
        end
    end

    always_ff @(posedge LINK_CLK) begin
        if (lnk_rst_ff || !LINK_FRAME_IN) begin
            lnk_st_ff  <= QEC_LNK_IDLE;
            lnk_sh_ff  <= '0;
            lnk_bit_ff <= '0;
            lnk_do_ff  <= 1'b1;
        end else begin
            case (lnk_st_ff)
                QEC_LNK_IDLE: begin
                    lnk_sh_ff  <= lnk_hold_ff;
                    lnk_bit_ff <= '0;
                    lnk_st_ff  <= QEC_LNK_SHIFT;
                end
                QEC_LNK_SHIFT: begin
                    lnk_do_ff  <= lnk_sh_ff[FW-1];
                    lnk_sh_ff  <= {lnk_sh_ff[FW-2:0], 1'b0};
                    lnk_bit_ff <= lnk_bit_ff + `QEC_FRAME_CW'(1);
                    if (lnk_bit_ff == `QEC_FRAME_CW'(FW - 1)) begin
                        lnk_st_ff <= QEC_LNK_IDLE;
                    end
                end
                default: lnk_st_ff <= QEC_LNK_IDLE;
            endcase
        end
    end
    assign LINK_DATA_OUT = lnk_do_ff;

    property p_probe_shift;
        @(posedge MCLK) disable iff (RESET)
        CLOCK_ENABLE && prb_trig |=> tp2_ff == $past(tp1_ff) && tp1_ff == $past(cnt_ff[0][23:0]);
    endproperty
    a_probe_shift: assert property (p_probe_shift) else $error("probe capture wrong");

    property p_sw_capture;
        @(posedge MCLK) disable iff (RESET)
        CLOCK_ENABLE && PROBE_CAPTURE_COMMAND |=> prb_val_ff;
    endproperty
    a_sw_capture: assert property (p_sw_capture) else $error("command missed");

    property p_double_change;
        @(posedge MCLK) disable iff (RESET)
        CLOCK_ENABLE && both[0] && mask[0] != '0 |=> $stable(cnt_ff[0]) && abz_err_ff[0];
    endproperty
    a_double_change: assert property (p_double_change) else $error("illegal step");

    property p_count_up;
        @(posedge MCLK) disable iff (RESET)
        CLOCK_ENABLE && step[0] && up[0] |=> cnt_ff[0] == (($past(cnt_ff[0]) + 48'h1) & $past(mask[0]));
    endproperty
    a_count_up: assert property (p_count_up) else $error("count up wrong");

    property p_default_24;
        @(posedge MCLK) cfg_ff.layout == `QEC_LAY_1X24 |-> mask[0] == 48'h0000_00FF_FFFF && mask[1] == '0;
    endproperty
    a_default_24: assert property (p_default_24) else $error("default width wrong");

    property p_width_sum;
        @(posedge MCLK) disable iff (RESET)
        7'(chan_w(cfg_ff.layout, 0)) + 7'(chan_w(cfg_ff.layout, 1))
            + 7'(chan_w(cfg_ff.layout, 2)) <= 7'(`QEC_W48);
    endproperty
    a_width_sum: assert property (p_width_sum) else $error("width over 48");

    property p_ext_sticky;
        @(posedge MCLK) disable iff (RESET)
        ext_err_ff && !STATUS_CLEAR ##1 CLOCK_ENABLE |-> ext_err_ff;
    endproperty
    a_ext_sticky: assert property (p_ext_sticky) else $error("external error lost");

    property p_idx_latch;
        @(posedge MCLK) disable iff (RESET)
        CLOCK_ENABLE && idx_rise && idx_seen_ff |=> idx_latch_ff == $past(idx_cnt_ff) && idx_cnt_ff == '0;
    endproperty
    a_idx_latch: assert property (p_idx_latch) else $error("index latch wrong");

    property p_err_drive;
        @(posedge MCLK) disable iff (RESET)
        CLOCK_ENABLE && (|abz_err_ff) |=> ERROR_LINE_LOW_OE && !ERROR_LINE_LOW_OUT;
    endproperty
    a_err_drive: assert property (p_err_drive) else $error("error line not driven");

    property p_open_filter;
        @(posedge MCLK) disable iff (RESET)
        SYNC_SERIAL_SELECT |-> filt_ff == `QEC_FILT_W'(`QEC_FILT_CYC) && $past(pins[9]);
    endproperty
    a_open_filter: assert property (p_open_filter) else $error("select too early");

endmodule // qec_counter

/* qec_regs.svh */
`ifndef QEC_REGS_SVH
`define QEC_REGS_SVH

`define QEC_CLK_NS      50
`define QEC_FILT_US     5
`define QEC_FILT_CYC    ((`QEC_FILT_US * 1000 + `QEC_CLK_NS - 1) / `QEC_CLK_NS)
`define QEC_FILT_W      8
`define QEC_CNT_W       48
`define QEC_IDX_W       24
`define QEC_FRAME_W     120
`define QEC_FRAME_CW    7
`define QEC_CFG_RST     6'h00
`define QEC_PIN_RST     10'h180
`define QEC_W0          6'h00
`define QEC_W16         6'h10
`define QEC_W24         6'h18
`define QEC_W32         6'h20
`define QEC_W48         6'h30
`define QEC_LAY_1X24    3'h0
`define QEC_LAY_1X16    3'h1
`define QEC_LAY_1X32    3'h2
`define QEC_LAY_1X48    3'h3
`define QEC_LAY_2X24    3'h4
`define QEC_LAY_2X16    3'h5
`define QEC_LAY_32_16   3'h6
`define QEC_LAY_3X16    3'h7
`define QEC_EDGE_RISE   2'h0
`define QEC_EDGE_FALL   2'h1

`endif

/* qec_pkg.sv */
package qec_pkg;
    `include "qec_regs.svh"

    typedef struct packed {
        logic [2:0] layout;
        logic       ttl_mode;
        logic [1:0] probe_edge;
    } qec_cfg_t;

    typedef struct packed {
        logic [2:0] abz_error;
        logic [2:0] overflow;
        logic       probe_valid;
        logic       idx_valid;
        logic       idx_latch_valid;
        logic       idx_overflow;
        logic       power_on;
        logic       ext_error;
        logic       ext_warning;
        logic       sync_serial;
    } qec_status_t;

    typedef enum logic [1:0] {
        QEC_LNK_IDLE  = 2'b01,
        QEC_LNK_SHIFT = 2'b10
    } qec_lnk_t;
endpackage

/* qec_link_master.sv */
`timescale 1ns/1ps
module qec_link_master (
    // Link pins.
    output logic         link_clk,
    output logic         link_frame,
    input  wire logic    link_data,
    // Bench side.
    output logic [119:0] rx
);
    // A few pulses during reset let the link side take the reset; then the clock stands still.
    initial begin
        link_clk = 1'b0;
        link_frame = 1'b0;
        rx = '0;
        repeat (4) begin
            #24 link_clk = 1'b1;
            #24 link_clk = 1'b0;
        end
    end
    // The clock runs inside a frame and for one pulse after it; its period is the bench's fixed 48 ns.
    task automatic frame();
        link_frame = 1'b1;
        for (int i = 0; i <= 120; i++) begin
            #24 link_clk = 1'b1;
            #24 link_clk = 1'b0;
            if (i > 0) rx = {rx[118:0], link_data};
        end
        link_frame = 1'b0;
        // One edge with the frame low returns the link to idle, also after a cut frame.
        #24 link_clk = 1'b1;
        #24 link_clk = 1'b0;
    endtask
endmodule // qec_link_master

/* quadrature_encoder_counter_tb_top.sv */
`timescale 1ns/1ps
`include "qec_regs.svh"
module quadrature_encoder_counter_tb_top;
    import qec_pkg::*;
    logic         mclk, reset, a, b, z, prb, cmd, cwr, ext_w, opn, eoe, woe, sel, lclk, lfr, ld;
    logic         ce, clr;
    logic [119:0] rx;
    logic [47:0]  c0;
    logic [23:0]  tl, tp, il, ic;
    qec_cfg_t     cfg;
    qec_status_t  st;
    int           n_errors, n_tests, cnt, p;
    logic [1:0]   seq [4] = '{2'b00, 2'b10, 2'b11, 2'b01};

    // Default wiring: A, B and index on the three positive inputs.
    // The A negative input also carries B, so the split layout sees the same pair.
    qec_counter u_dut (.MCLK(mclk), .RESET(reset), .CLOCK_ENABLE(ce),
        .TRACK_A_POS_IN(a), .TRACK_A_NEG_IN(b), .TRACK_B_POS_IN(b),
        .TRACK_B_NEG_IN(1'b0), .TRACK_C_POS_IN(z), .TRACK_C_NEG_IN(1'b0),
        .PROBE_TRIGGER_IN(prb), .PROBE_CAPTURE_COMMAND(cmd), .CONFIG_DATA(cfg),
        .CONFIG_WRITE(cwr), .STATUS_CLEAR(clr), .ERROR_LINE_LOW_IN(!eoe),
        .ERROR_LINE_LOW_OUT(), .ERROR_LINE_LOW_OE(eoe), .WARNING_LINE_LOW_IN(!(woe || ext_w)),
        .WARNING_LINE_LOW_OUT(), .WARNING_LINE_LOW_OE(woe), .SERIAL_RETURN_OPEN_IN(opn),
        .SYNC_SERIAL_SELECT(sel), .COUNTER_FIRST(c0), .COUNTER_SECOND(), .COUNTER_THIRD(),
        .PROBE_CAPTURE_LATEST(tl), .PROBE_CAPTURE_PREVIOUS(tp), .INDEX_DISTANCE_LATCH(il),
        .INDEX_DISTANCE_COUNT(ic), .STATUS(st), .LINK_CLK(lclk), .LINK_FRAME_IN(lfr),
        .LINK_DATA_OUT(ld));
    qec_link_master u_lnk (.link_clk(lclk), .link_frame(lfr), .link_data(ld), .rx(rx));

    task automatic chk(input logic [47:0] s, input logic [47:0] e, input string m);
        n_tests++;
        if (s !== e) begin
            n_errors++;
            $display("unexpected %0t %s", $time, m);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(negedge mclk);
    endtask
    // Steps are spaced five cycles apart, far below the count limit.
    task automatic mv(input int n);
        for (int i = 0; i < (n < 0 ? -n : n); i++) begin
            p = (p + (n < 0 ? 3 : 1)) % 4;
            {a, b} = seq[p];
            cnt += (n < 0 ? -1 : 1);
            wt(5);
        end
    endtask
    // A write strobe stands for a finished host transfer; its serial clock is not modelled.
    task automatic cfgw(input qec_cfg_t c);
        cfg = c;
        cwr = 1'b1;
        wt(1);
        cwr = 1'b0;
    endtask
    task automatic idx();
        z = 1'b1;
        wt(5);
        z = 1'b0;
        wt(5);
    endtask
    task automatic t_count();
        mv(8);
        mv(-3);
        chk(c0, 48'(cnt), "count");
        ce = 1'b0;
        mv(1);
        chk(c0, 48'(cnt - 1), "frozen count");
        ce = 1'b1;
        wt(5);
        chk(c0, 48'(cnt), "resumed count");
    endtask
    task automatic t_illegal();
        p = (p + 2) % 4;
        {a, b} = seq[p];
        wt(5);
        chk(c0, 48'(cnt), "count after illegal step");
        chk(st.abz_error[0], 1'b1, "phase error flag");
        chk(eoe, 1'b1, "error line drive");
    endtask
    task automatic t_index();
        idx();
        mv(5);
        chk(ic, 48'd5, "running distance");
        idx();
        chk(il, 48'd5, "first index distance");
        mv(2);
        idx();
        chk(il, 48'd2, "later index distance");
        chk(st.idx_latch_valid, 1'b1, "latch valid");
    endtask
    task automatic t_probe();
        prb = 1'b1;
        wt(5);
        chk(tl, 48'(cnt[23:0]), "rising only");
        mv(1);
        prb = 1'b0;
        wt(5);
        chk(tl, 48'(cnt[23:0] - 24'h1), "falling ignored");
        cfgw('{layout: 3'h0, ttl_mode: 1'b0, probe_edge: 2'h2});
        cmd = 1'b1;
        wt(1);
        cmd = 1'b0;
        wt(2);
        chk(tl, 48'(cnt[23:0]), "command capture");
        mv(1);
        prb = 1'b1;
        wt(5);
        chk(tl, 48'(cnt[23:0]), "rising capture");
        chk(tp, 48'(cnt[23:0] - 24'h1), "previous capture");
        mv(1);
        prb = 1'b0;
        wt(5);
        chk(tl, 48'(cnt[23:0]), "falling capture");
        cfgw('{layout: 3'h0, ttl_mode: 1'b0, probe_edge: 2'h1});
        mv(1);
        prb = 1'b1;
        wt(5);
        chk(tl, 48'(cnt[23:0] - 24'h1), "rising ignored");
        prb = 1'b0;
        wt(5);
        chk(tl, 48'(cnt[23:0]), "falling only");
    endtask
    task automatic t_warn();
        ext_w = 1'b1;
        wt(6);
        ext_w = 1'b0;
        wt(6);
        chk(st.ext_warning, 1'b1, "external warning sticky");
    endtask
    task automatic t_open();
        opn = 1'b1;
        wt(60);
        chk(sel, 1'b0, "select too early");
        wt(50);
        chk(sel, 1'b1, "select after filter");
        opn = 1'b0;
        wt(4);
        chk(sel, 1'b0, "select cleared");
    endtask
    task automatic t_link();
        u_lnk.frame();
        u_lnk.frame();
        chk(rx[119:72], 48'(cnt[23:0]), "frame counter");
        chk(rx[71:48], 48'(cnt[23:0]), "frame latest");
        chk(rx[47:24], 48'(cnt[23:0] - 24'h1), "frame previous");
        chk(rx[23:0], 48'd2, "frame index latch");
    endtask
    task automatic t_clear();
        chk(st.power_on, 1'b1, "power-on flag");
        chk(st.ext_error, 1'b0, "no false external error");
        clr = 1'b1;
        wt(1);
        clr = 1'b0;
        wt(6);
        chk(st.power_on, 1'b0, "power-on cleared");
        chk(st.abz_error[0], 1'b0, "phase error cleared");
        chk(eoe, 1'b0, "error line released");
        chk(st.ext_error, 1'b0, "own release not external");
    endtask
    task automatic t_split();
        cfgw('{layout: `QEC_LAY_3X16, ttl_mode: 1'b0, probe_edge: `QEC_EDGE_RISE});
        mv(3);
        chk(c0, 48'(cnt[15:0]), "split counter");
    endtask
    task automatic test_done();
        if (n_errors == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    initial begin
        #200000;
        n_errors++;
        test_done();
    end
    initial begin
        reset = 1'b1;
        {a, b, z, prb, cmd, cwr, ext_w, opn, clr} = '0;
        ce = 1'b1;
        cfg = '0;
        repeat (12) @(negedge mclk);
        reset = 1'b0;
        wt(4);
        t_count();
        t_illegal();
        t_index();
        t_probe();
        t_warn();
        t_clear();
        t_open();
        t_link();
        t_split();
        test_done();
    end
endmodule // quadrature_encoder_counter_tb_top
